/* File: common/mbc_regs.svh */
/*
 * Register offsets, reset values and timing counts
 * for the modulation and bit rate control block.
 * Assumes inclusion by bare name from design and verification files.
 */
`ifndef MBC_REGS_SVH
`define MBC_REGS_SVH

`define MBC_IDX_CUR_ATTEN   10'h00E
`define MBC_IDX_RATE_FILT   10'h00F
`define MBC_IDX_CLK_DIV     10'h010
`define MBC_OFF_CUR_ATTEN   {`MBC_IDX_CUR_ATTEN, 2'b00}
`define MBC_OFF_RATE_FILT   {`MBC_IDX_RATE_FILT, 2'b00}
`define MBC_OFF_CLK_DIV     {`MBC_IDX_CLK_DIV, 2'b00}
`define MBC_OFF_SCHEME      12'h02C
`define MBC_OFF_AMP_CTRL    12'h044
`define MBC_OFF_AMP_RATE    12'h048
`define MBC_OFF_STATUS      12'h080

`define MBC_RST_CUR_ATTEN   8'h4B
`define MBC_RST_RATE_FILT   8'h24
`define MBC_RST_CLK_DIV     8'h34
`define MBC_RST_SCHEME      8'h00
`define MBC_RST_AMP_CTRL    8'h3F
`define MBC_RST_AMP_RATE    8'hB4

`define MBC_FREQ_BASE_EXP   3
`define MBC_AMP_BASE_EXP    5
`define MBC_PN_SEED         4'hF
`define MBC_AMP_STEP_DB     3

`endif

/* File: common/mbc_pkg.sv */
/*
 * Types for the modulation and bit rate control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mbc_pkg;
   typedef enum logic [2:0] {
      MBC_CLOSED_LOOP,
      MBC_OPEN_LOOP,
      MBC_DIVIDER,
      MBC_AMP_PLAIN,
      MBC_AMP_DITHER,
      MBC_IDLE
   } mbc_scheme_t;
endpackage

/* File: src/mbc_rate_gen.sv */
/*
 * Bit strobe generator: divisor counter then power-of-two prescaler.
 * Assumes divisor of at least one; a zero divisor is treated as one.
 */
`timescale 1ns/1ps
`default_nettype none
module mbc_rate_gen (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [5:0] divisor,
   input  wire logic [3:0] exponent,
   output logic            div_tick,
   output logic            strobe
);
   logic [5:0]  div_cnt;
   logic [8:0]  pre_cnt;
   logic [8:0]  pre_top;
   wire         div_end = (div_cnt == 6'h00);
   wire  [5:0]  div_load = (divisor == 6'h00) ? 6'h00 : divisor - 6'h01;

   // Reload on terminal count keeps every bit period the same length
   assign pre_top = 9'((10'h001 << exponent) - 10'h001);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt  <= 6'h00;
         pre_cnt  <= 9'h000;
         div_tick <= 1'b0;
         strobe   <= 1'b0;
      end else begin
         div_tick <= div_end;
         strobe   <= div_end && (pre_cnt == 9'h000);
         div_cnt  <= div_end ? div_load : div_cnt - 6'h01;
         if (div_end) begin
            pre_cnt <= (pre_cnt == 9'h000) ? pre_top : pre_cnt - 9'h001;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/mbc_top.sv */
/*
 * Modulation selection and bit rate control: APB register slave,
 * two bit strobes, dither pattern, divider select, power keying and
 * charge pump control.
 * Assumes APB master on SYS_CLK and synchronous pin inputs.
 */
// Added by the designer: the APB slave port.
// Operation
// - Scheme chosen from two-bit select plus amplitude keying enable
// - Select 0: data drives oscillator, loop stays closed
// - Select 1: loop on while pin tristated, else off and pin sent
// - Open loop buffered data: loop off for each packet only
// - Select 2: divider set follows each transmitted bit
// - Amplitude keying only with enable 1 and select 2 or 3
// - Zero symbol at power minus backoff steps of 3dB, one at full
// - Power not above backoff turns zero symbols fully off
// - Three-bit ramp select sets edge shaping, 7 strongest
// - Dithered keying uses divider switching at faster chip rate
// - Sequence select: 0 gives 010101, 1 gives fifteen-bit pattern
// - Frequency rate is crystal over divisor over 2^(3+exponent); exponent 7 divides by 2^9, as 6 does
// - Amplitude rate is crystal over divisor over 2^(5+exponent)
// - Two bit clocks independent; frequency one sets dither chips
// - Charge injected at each data change in select 0 or 1, ends at next modulator clock tick
// - Attenuation then low-pass smoothing settings passed to modulator
// - Modulator clock is crystal over frequency divisor
// - Shaping factor is two to the frequency exponent
`timescale 1ns/1ps
`default_nettype none
`include "mbc_regs.svh"
module mbc_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic [31:0]      PRDATA,
   output logic             PSLVERR,
   input  wire logic        TX_DATA_PIN,
   input  wire logic        TX_DATA_PIN_DRIVEN,
   input  wire logic        BUF_DATA,
   input  wire logic        BUF_PACKET_ACTIVE,
   input  wire logic        BUF_SOURCE,
   output logic             LOOP_ENABLE,
   output logic             OSC_MOD_DATA,
   output logic             DIVIDER_SET_ONE,
   output logic             AMP_SYMBOL_ONE,
   output logic [2:0]       PA_LEVEL,
   output logic             PA_OFF,
   output logic [2:0]       AMP_RAMP,
   output logic             CHARGE_PULSE,
   output logic             MOD_CLK_TICK,
   output logic [4:0]       MOD_CURRENT,
   output logic [2:0]       MOD_ATTEN,
   output logic [2:0]       MOD_FILTER,
   output logic [2:0]       SHAPE_EXP,
   output logic             FREQ_STROBE,
   output logic             AMP_STROBE
);
   import mbc_pkg::*;

   logic [7:0]  cur_atten;
   logic [7:0]  rate_filt;
   logic [7:0]  clk_div;
   logic [7:0]  scheme_reg;
   logic [7:0]  amp_ctrl;
   logic [7:0]  amp_rate;
   logic [3:0]  pn_lfsr;
   logic        alt_chip;
   logic        data_q;
   logic        chip;
   mbc_scheme_t scheme;
   mbc_scheme_t scheme_q;

   wire [1:0] mod_sel     = scheme_reg[1:0];
   wire [2:0] power_level = scheme_reg[4:2];
   wire       amplitude_keying_enable = amp_ctrl[6];
   wire       dither_sequence_select  = amp_ctrl[7];
   wire [2:0] amplitude_ramp_select   = amp_ctrl[5:3];
   wire [2:0] amplitude_backoff_steps = amp_ctrl[2:0];
   wire [5:0] freq_clock_divisor = clk_div[5:0];
   wire [2:0] freq_rate_exponent = rate_filt[5:3];
   wire [5:0] amp_clock_divisor  = amp_rate[5:0];
   wire [1:0] amp_rate_exponent  = amp_rate[7:6];

   // APB: zero wait states, unmapped reads zero and flags an error
   wire access   = PSEL && PENABLE;
   wire wr       = access && PWRITE;
   wire hit_cur  = (PADDR == `MBC_OFF_CUR_ATTEN);
   wire hit_rate = (PADDR == `MBC_OFF_RATE_FILT);
   wire hit_div  = (PADDR == `MBC_OFF_CLK_DIV);
   wire hit_sch  = (PADDR == `MBC_OFF_SCHEME);
   wire hit_amp  = (PADDR == `MBC_OFF_AMP_CTRL);
   wire hit_arat = (PADDR == `MBC_OFF_AMP_RATE);
   wire hit_stat = (PADDR == `MBC_OFF_STATUS);
   wire mapped   = hit_cur | hit_rate | hit_div | hit_sch | hit_amp
                 | hit_arat | hit_stat;
   logic [31:0] rd_mux;
   always_comb begin
      if (hit_cur)       rd_mux = {24'h000000, cur_atten};
      else if (hit_rate) rd_mux = {24'h000000, rate_filt};
      else if (hit_div)  rd_mux = {24'h000000, clk_div};
      else if (hit_sch)  rd_mux = {24'h000000, scheme_reg};
      else if (hit_amp)  rd_mux = {24'h000000, amp_ctrl};
      else if (hit_arat) rd_mux = {24'h000000, amp_rate};
      else if (hit_stat) rd_mux = {24'h000000, LOOP_ENABLE,
                                   DIVIDER_SET_ONE, AMP_SYMBOL_ONE,
                                   PA_OFF, chip, scheme_q};
      else               rd_mux = 32'h00000000;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cur_atten  <= `MBC_RST_CUR_ATTEN;
         rate_filt  <= `MBC_RST_RATE_FILT;
         clk_div    <= `MBC_RST_CLK_DIV;
         scheme_reg <= `MBC_RST_SCHEME;
         amp_ctrl   <= `MBC_RST_AMP_CTRL;
         amp_rate   <= `MBC_RST_AMP_RATE;
      end else if (wr) begin
         if (hit_cur)  cur_atten  <= PWDATA[7:0];
         if (hit_rate) rate_filt  <= PWDATA[7:0];
         if (hit_div)  clk_div    <= PWDATA[7:0];
         if (hit_sch)  scheme_reg <= PWDATA[7:0];
         if (hit_amp)  amp_ctrl   <= PWDATA[7:0];
         if (hit_arat) amp_rate   <= PWDATA[7:0];
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : PRDATA;
         PSLVERR <= PSEL && !PENABLE && !mapped;
      end
   end

   // Scheme decode
   // Keying with select 2 is the dithered form, chips on the dividers
   assign scheme = (mod_sel == 2'h0) ? MBC_CLOSED_LOOP :
                   (mod_sel == 2'h1) ? MBC_OPEN_LOOP :
                   (mod_sel == 2'h3) ? (amplitude_keying_enable
                                        ? MBC_AMP_PLAIN : MBC_IDLE) :
                   amplitude_keying_enable ? MBC_AMP_DITHER :
                   MBC_DIVIDER;

   // Strobes derived independently
   logic freq_strobe_i;
   logic amp_strobe_i;
   logic mod_tick_i;
   mbc_rate_gen u_freq_rate (
      .clk      (SYS_CLK),
      .rst      (RST),
      .divisor  (freq_clock_divisor),
      .exponent (4'(freq_rate_exponent) + 4'(`MBC_FREQ_BASE_EXP)),
      .div_tick (mod_tick_i),
      .strobe   (freq_strobe_i)
   );
   mbc_rate_gen u_amp_rate (
      .clk      (SYS_CLK),
      .rst      (RST),
      .divisor  (amp_clock_divisor),
      .exponent (4'(amp_rate_exponent) + 4'(`MBC_AMP_BASE_EXP)),
      .div_tick (),
      .strobe   (amp_strobe_i)
   );

   // Data source: buffered packet or pin
   wire tx_bit = BUF_SOURCE ? BUF_DATA : TX_DATA_PIN;
   wire entering_dither = (scheme == MBC_AMP_DITHER)
                       && (scheme_q != MBC_AMP_DITHER);
   // Taps chosen so seed F yields 111101011001000 from its first chip
   wire pn_fb = pn_lfsr[3] ^ pn_lfsr[0];
   wire next_chip = dither_sequence_select ? pn_lfsr[3] : alt_chip;

   // Dither chips advance on the frequency strobe
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pn_lfsr  <= `MBC_PN_SEED;
         alt_chip <= 1'b0;
         chip     <= 1'b0;
         scheme_q <= MBC_CLOSED_LOOP;
      end else begin
         scheme_q <= scheme;
         if (entering_dither) begin
            pn_lfsr  <= `MBC_PN_SEED;
            alt_chip <= 1'b0;
            chip     <= 1'b0;
         end else if (freq_strobe_i) begin
            pn_lfsr  <= {pn_lfsr[2:0], pn_fb};
            alt_chip <= !alt_chip;
            chip     <= next_chip;
         end
      end
   end

   // Loop and divider control
   wire open_loop_off = BUF_SOURCE ? BUF_PACKET_ACTIVE
                                   : TX_DATA_PIN_DRIVEN;
   wire next_loop = (scheme == MBC_OPEN_LOOP) ? !open_loop_off : 1'b1;
   wire next_div_one = (scheme == MBC_DIVIDER) ? tx_bit :
                       (scheme == MBC_AMP_DITHER) ? chip :
                       1'b0;

   // Power keying: backoff of 3dB steps, full off when not above
   wire amp_on = (scheme == MBC_AMP_PLAIN) || (scheme == MBC_AMP_DITHER);
   wire on_off_keying = (power_level <= amplitude_backoff_steps);
   wire [2:0] zero_level = on_off_keying ? 3'h0
                         : power_level - amplitude_backoff_steps;
   wire [2:0] next_pa = (!amp_on || tx_bit) ? power_level : zero_level;
   wire next_pa_off = amp_on && !tx_bit && on_off_keying;

   // Charge pulse: set per data change, cleared at the next modulator clock tick
   wire vco_mode = (scheme == MBC_CLOSED_LOOP)
                || (scheme == MBC_OPEN_LOOP);
   wire data_edge = vco_mode && (tx_bit != data_q);

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         data_q          <= 1'b0;
         CHARGE_PULSE    <= 1'b0;
         LOOP_ENABLE     <= 1'b1;
         OSC_MOD_DATA    <= 1'b0;
         DIVIDER_SET_ONE <= 1'b0;
         AMP_SYMBOL_ONE  <= 1'b1;
         PA_LEVEL        <= 3'h0;
         PA_OFF          <= 1'b0;
      end else begin
         data_q <= tx_bit;
         // Pulse ends at the next modulator clock tick, so width follows that clock
         if (data_edge) begin
            CHARGE_PULSE <= 1'b1;
         end else if (mod_tick_i) begin
            CHARGE_PULSE <= 1'b0;
         end
         LOOP_ENABLE     <= next_loop;
         OSC_MOD_DATA    <= vco_mode ? tx_bit : 1'b0;
         DIVIDER_SET_ONE <= next_div_one;
         AMP_SYMBOL_ONE  <= !amp_on || tx_bit;
         PA_LEVEL        <= next_pa;
         PA_OFF          <= next_pa_off;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         AMP_RAMP     <= 3'h0;
         MOD_CURRENT  <= 5'h00;
         MOD_ATTEN    <= 3'h0;
         MOD_FILTER   <= 3'h0;
         SHAPE_EXP    <= 3'h0;
         MOD_CLK_TICK <= 1'b0;
         FREQ_STROBE  <= 1'b0;
         AMP_STROBE   <= 1'b0;
      end else begin
         AMP_RAMP     <= amplitude_ramp_select;
         MOD_CURRENT  <= cur_atten[7:3];
         MOD_ATTEN    <= cur_atten[2:0];
         MOD_FILTER   <= rate_filt[2:0];
         SHAPE_EXP    <= freq_rate_exponent;
         MOD_CLK_TICK <= mod_tick_i;
         FREQ_STROBE  <= freq_strobe_i;
         AMP_STROBE   <= amp_strobe_i;
      end
   end

   AST_DIV_FOLLOWS_BIT: assert property (@(posedge SYS_CLK)
      disable iff (RST)
      (scheme == MBC_DIVIDER) |=> (DIVIDER_SET_ONE == $past(tx_bit)))
      else $error("divider set does not follow data");
   AST_AMP_GATED: assert property (@(posedge SYS_CLK) disable iff (RST)
      (!amplitude_keying_enable || !mod_sel[1]) |=> AMP_SYMBOL_ONE)
      else $error("amplitude keying without enable and keying select");
   AST_OOK_OFF: assert property (@(posedge SYS_CLK) disable iff (RST)
      (amp_on && !tx_bit && on_off_keying) |=> (PA_OFF && PA_LEVEL == 3'h0))
      else $error("zero symbol not fully off");
   AST_BACKOFF: assert property (@(posedge SYS_CLK) disable iff (RST)
      (amp_on && !tx_bit && !on_off_keying) |=>
      (PA_LEVEL == $past(power_level) - $past(amplitude_backoff_steps)))
      else $error("backoff level wrong");
   AST_OPEN_LOOP: assert property (@(posedge SYS_CLK) disable iff (RST)
      (scheme == MBC_OPEN_LOOP && !BUF_SOURCE) |=>
      (LOOP_ENABLE == !$past(TX_DATA_PIN_DRIVEN)))
      else $error("open loop control wrong");
   AST_PACKET_LOOP: assert property (@(posedge SYS_CLK) disable iff (RST)
      (scheme == MBC_OPEN_LOOP && BUF_SOURCE && BUF_PACKET_ACTIVE)
      |=> !LOOP_ENABLE)
      else $error("loop on during packet");
   AST_CLOSED: assert property (@(posedge SYS_CLK) disable iff (RST)
      (scheme == MBC_CLOSED_LOOP) |=> (LOOP_ENABLE
      && OSC_MOD_DATA == $past(tx_bit)))
      else $error("closed loop path wrong");
   AST_DITHER_RST: assert property (@(posedge SYS_CLK) disable iff (RST)
      entering_dither |=> (chip == 1'b0 && pn_lfsr == `MBC_PN_SEED))
      else $error("dither not restarted");
   AST_CHARGE: assert property (@(posedge SYS_CLK) disable iff (RST)
      data_edge |=> CHARGE_PULSE)
      else $error("no charge on data change");
   AST_STROBE_SPACE: assert property (@(posedge SYS_CLK)
      disable iff (RST)
      (freq_strobe_i && freq_clock_divisor != 6'h00) |=> !freq_strobe_i)
      else $error("frequency strobes too close");
endmodule
`default_nettype wire

/* File: verification/mbc_host_model.sv */
/*
 * Host model: APB register master and transmit data source.
 * Assumes the bench supplies SYS_CLK and holds reset at start.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mbc_regs.svh"
module mbc_host_model (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             pin,
   output logic             pin_driven,
   output logic             buf_bit,
   output logic             packet,
   output logic             use_buf
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pin, pin_driven, buf_bit, packet, use_buf} = '0;
   end

   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Released pin shows the inverse, never a stale level
   task automatic set_pin(input logic drv, input logic lvl);
      @(posedge clk);
      pin_driven <= drv;
      pin <= drv ? lvl : ~pin;
   endtask

   task automatic set_buf(input logic src, input logic pkt,
      input logic b);
      @(posedge clk);
      use_buf <= src;
      packet <= pkt;
      buf_bit <= b;
   endtask

   task automatic freq_cfg(input logic [5:0] k, input logic [2:0] n,
      input logic [2:0] f);
      logic [31:0] q;
      logic        e;
      if (k == 6'h00) k = 6'h01;
      if (n > 3'h5) n = 3'h5;
      // Biphase framing assumed, so a zero exponent is avoided
      if (n == 3'h0) n = 3'h1;
      xfer(1'b1, `MBC_OFF_RATE_FILT, {2'b00, n, f}, q, e);
      xfer(1'b1, `MBC_OFF_CLK_DIV, {2'b00, k}, q, e);
   endtask
endmodule
`default_nettype wire

/* File: verification/modulation_bitrate_control_test.sv */
/*
 * Bench for the modulation and bit rate control block.
 * Assumes the host model as register master and data source.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mbc_regs.svh"
module modulation_bitrate_control_test;
   localparam logic [14:0] DITHER_PN = 15'b111101011001000;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pin, drv, bbit, pkt, src, loop_en, osc, div1, sym1;
   logic        pa_off, charge, tick, fstb, astb, e;
   logic [2:0]  pa_lvl, ramp, att, filt, shp;
   logic [4:0]  cur;
   logic [15:0] cs;
   int          mismatches, checks, n;

   mbc_host_model host (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin(pin),
      .pin_driven(drv), .buf_bit(bbit), .packet(pkt), .use_buf(src));

   mbc_top uut (.SYS_CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .TX_DATA_PIN(pin), .TX_DATA_PIN_DRIVEN(drv),
      .BUF_DATA(bbit), .BUF_PACKET_ACTIVE(pkt), .BUF_SOURCE(src),
      .LOOP_ENABLE(loop_en), .OSC_MOD_DATA(osc),
      .DIVIDER_SET_ONE(div1), .AMP_SYMBOL_ONE(sym1), .PA_LEVEL(pa_lvl),
      .PA_OFF(pa_off), .AMP_RAMP(ramp), .CHARGE_PULSE(charge),
      .MOD_CLK_TICK(tick), .MOD_CURRENT(cur), .MOD_ATTEN(att),
      .MOD_FILTER(filt), .SHAPE_EXP(shp), .FREQ_STROBE(fstb),
      .AMP_STROBE(astb));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q, e);
      chk(e, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, 8'h00, q, e);
      chk(q, {24'h000000, d});
      chk(e, 1'b0);
   endtask

   // Wide settle: registered outputs follow data one clock after it changes
   task automatic settle;
      repeat (200) @(posedge clk);
   endtask

   // Fields: loop, osc, div1, sym1, pa_off, pa_lvl
   task automatic obs(input logic d, input logic l, input logic [7:0] m,
      input logic [7:0] x);
      host.set_pin(d, l);
      settle;
      chk({loop_en, osc, div1, sym1, pa_off, pa_lvl} & m, x & m);
   endtask

   function automatic logic pulse(input int s);
      return s == 0 ? tick : (s == 1 ? fstb : astb);
   endfunction

   // First spans sync to the new setting; the last one counts
   task automatic gap(input int s, output int p);
      repeat (3) begin
         p = 0;
         do begin
            @(posedge clk);
            p++;
         end while (pulse(s) !== 1'b1);
      end
   endtask

   // Chip seen on the divider select two edges after each strobe
   task automatic chips(output logic [15:0] s);
      for (int i = 0; i < 16; i++) begin
         do @(posedge clk); while (fstb !== 1'b1);
         repeat (2) @(posedge clk);
         s[i] = div1;
      end
   endtask

   task automatic dither(output int r);
      logic [15:0] s;
      int          ok;
      chips(s);
      r = 99;
      for (int k = 14; k >= 0; k--) begin
         ok = 1;
         for (int i = 0; i < 16; i++)
            if (s[i] !== DITHER_PN[14 - ((i + k) % 15)]) ok = 0;
         if (ok == 1) r = k;
      end
   endtask

   task automatic wrap_up;
      if (mismatches == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      wrap_up;
   end

   initial begin
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(`MBC_OFF_CUR_ATTEN, `MBC_RST_CUR_ATTEN);
      rd(`MBC_OFF_RATE_FILT, `MBC_RST_RATE_FILT);
      rd(`MBC_OFF_CLK_DIV, `MBC_RST_CLK_DIV);
      rd(`MBC_OFF_SCHEME, `MBC_RST_SCHEME);
      rd(`MBC_OFF_AMP_CTRL, `MBC_RST_AMP_CTRL);
      rd(`MBC_OFF_AMP_RATE, `MBC_RST_AMP_RATE);
      host.xfer(1'b1, 12'h004, 8'hFF, q, e);
      chk(e, 1'b1);
      host.xfer(1'b0, 12'h004, 8'h00, q, e);
      chk(q, 32'h00000000);
      chk(e, 1'b1);
      wr(`MBC_OFF_CUR_ATTEN, 8'hA5);
      rd(`MBC_OFF_CUR_ATTEN, 8'hA5);
      host.freq_cfg(6'h02, 3'h1, 3'h6);
      settle;
      chk({cur, att, filt, shp}, {5'h14, 3'h5, 3'h6, 3'h1});
      gap(0, n);
      chk(n, 32'h2);
      gap(1, n);
      chk(n, 32'h20);
      wr(`MBC_OFF_AMP_RATE, 8'h43);
      gap(2, n);
      chk(n, 32'hC0);
      wr(`MBC_OFF_SCHEME, 8'h14);
      obs(1'b1, 1'b1, 8'hC0, 8'hC0);
      host.set_pin(1'b1, 1'b0);
      n = 0;
      while (charge !== 1'b1 && n < 6) begin
         @(posedge clk);
         n++;
      end
      chk(charge, 1'b1);
      obs(1'b1, 1'b0, 8'hC0, 8'h80);
      wr(`MBC_OFF_SCHEME, 8'h15);
      obs(1'b0, 1'b0, 8'h80, 8'h80);
      obs(1'b1, 1'b1, 8'hC0, 8'h40);
      obs(1'b1, 1'b0, 8'hC0, 8'h00);
      host.set_buf(1'b1, 1'b1, 1'b0);
      settle;
      chk(loop_en, 1'b0);
      host.set_buf(1'b1, 1'b0, 1'b0);
      settle;
      chk(loop_en, 1'b1);
      host.set_buf(1'b0, 1'b0, 1'b0);
      wr(`MBC_OFF_SCHEME, 8'h16);
      obs(1'b1, 1'b1, 8'h20, 8'h20);
      obs(1'b1, 1'b0, 8'h20, 8'h00);
      wr(`MBC_OFF_SCHEME, 8'h17);
      obs(1'b1, 1'b0, 8'h10, 8'h10);
      wr(`MBC_OFF_AMP_CTRL, 8'h72);
      obs(1'b1, 1'b1, 8'h1F, 8'h15);
      chk(ramp, 3'h6);
      obs(1'b1, 1'b0, 8'h1F, 8'h03);
      wr(`MBC_OFF_AMP_CTRL, 8'h75);
      obs(1'b1, 1'b0, 8'h1F, 8'h08);
      wr(`MBC_OFF_SCHEME, 8'h15);
      obs(1'b1, 1'b0, 8'h10, 8'h10);
      wr(`MBC_OFF_SCHEME, 8'h17);
      wr(`MBC_OFF_AMP_CTRL, 8'hF2);
      wr(`MBC_OFF_SCHEME, 8'h16);
      // Restart shows as the first chip, or as a zero just before it
      dither(n);
      chk(n == 0 || n == 14, 1'b1);
      wr(`MBC_OFF_AMP_CTRL, 8'h72);
      chips(cs);
      chk(cs[15:2] ^ cs[14:1], 14'h3FFF);
      wrap_up;
   end
endmodule
`default_nettype wire
